// ==== rtl/adcs_top.sv ====
// adcs_top: conversion sequencer for an 8/10-bit successive approximation
// converter with eight inputs, APB registers and completion requests.
// Assumes comparator and trigger pin are asynchronous; timer is on pclk.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "adcs_map.svh"
module adcs_top (
   // Clock and reset
   input  logic        pclk,
   input  logic        presetn,
   // APB slave
   input  logic        psel,
   input  logic        penable,
   input  logic        pwrite,
   input  logic [11:0] paddr,
   input  logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic        pready,
   output logic        pslverr,
   // Start sources
   input  logic        tmr_trig,
   input  logic        ext_trig_n,
   // Analog front end
   input  logic        cmp_in,
   output logic [2:0]  ch_sel,
   output logic        sample_on,
   output logic [9:0]  dac_code,
   // Completion service
   input  logic        xfer_done,
   output logic        irq_req,
   output logic        xfer_req
);
   adcs_pkg::adcs_state_s s_ff;
   adcs_pkg::adcs_state_s nxt_s;
   adcs_pkg::adcs_mode_e  mode;
   adcs_pkg::adcs_trg_e   src;
   logic [12:0]           samp_len;
   logic [12:0]           cmp_len;
   logic [3:0]            lsb;
   logic [2:0]            st_ch;
   logic [2:0]            en_ch;
   logic [2:0]            start_ch;
   logic [9:0]            res_val;
   logic [2:0]            adv;
   logic                  res10;
   logic                  ien;
   logic                  transfer_service_enable;
   logic                  acc;
   logic                  hit_ctrl;
   logic                  hit_cmd;
   logic                  hit_res;
   logic                  bad;
   logic                  wr;
   logic                  go_sw;
   logic                  stop;
   logic                  clr_done;
   logic                  ext_fall;
   logic                  trig;
   logic                  fin;
   logic                  last;
   logic                  sar_on;
   logic                  fin_x;

   // Control field views
   assign mode  = adcs_pkg::adcs_mode_e'(s_ff.ctrl[`ADCS_F_MODE]);
   assign src   = adcs_pkg::adcs_trg_e'(s_ff.ctrl[`ADCS_F_TRIG]);
   assign res10 = s_ff.ctrl[`ADCS_F_RES10];
   assign ien   = s_ff.ctrl[`ADCS_F_IEN];
   assign transfer_service_enable   = s_ff.ctrl[`ADCS_F_XSE];
   assign st_ch = s_ff.ctrl[`ADCS_F_STCH];
   assign en_ch = s_ff.ctrl[`ADCS_F_ENCH];

   // Phase lengths; code 3 repeats the longest setting
   assign samp_len = (s_ff.ctrl[`ADCS_F_SAMP] == 2'h0) ? `ADCS_SAMP0 :
                     (s_ff.ctrl[`ADCS_F_SAMP] == 2'h1) ? `ADCS_SAMP1 :
                     `ADCS_SAMP2;
   assign cmp_len  = (s_ff.ctrl[`ADCS_F_CMP] == 2'h0) ? `ADCS_CMP0 :
                     (s_ff.ctrl[`ADCS_F_CMP] == 2'h1) ? `ADCS_CMP1 :
                     `ADCS_CMP2;
   assign lsb = res10 ? 4'h0 : 4'h2;

   // Incremental resumes where it paused; 8-bit keeps the top bits
   assign start_ch = (mode == adcs_pkg::ADCS_INCR) ? s_ff.nch : st_ch;
   assign res_val  = res10 ? s_ff.trial : {2'h0, s_ff.trial[9:2]};

   // APB decode; every access has one wait state
   assign acc      = psel & penable;
   assign hit_ctrl = paddr == `ADCS_CTRL_OFS;
   assign hit_cmd  = paddr == `ADCS_CMD_OFS;
   assign hit_res  = paddr == `ADCS_RES_OFS;
   assign bad      = ~(hit_ctrl | hit_cmd | hit_res);
   assign wr       = acc & s_ff.rdy & pwrite & ~bad;
   assign go_sw    = wr & hit_cmd & pwdata[`ADCS_F_GO];
   assign stop     = wr & hit_cmd & pwdata[`ADCS_F_STOP];
   assign clr_done = wr & hit_cmd & pwdata[`ADCS_F_DONE];

   // Start sources; only the second and third pin stages are compared
   assign ext_fall = s_ff.e3 & ~s_ff.e2;
   assign trig = (src == adcs_pkg::ADCS_TRG_SW  & go_sw) |
                 (src == adcs_pkg::ADCS_TRG_TMR & tmr_trig) |
                 (src == adcs_pkg::ADCS_TRG_EXT & ext_fall);

   // Sequencing terms
   assign fin    = s_ff.st == adcs_pkg::ADCS_CMP &&
                   s_ff.cnt == cmp_len - 13'h0001;
   assign last   = s_ff.ch == en_ch;
   assign adv    = last ? st_ch : s_ff.ch + 3'h1;
   assign sar_on = s_ff.bitn != 4'hF && s_ff.bitn >= lsb;
   assign fin_x  = fin & ien & transfer_service_enable;

   // Next state of the whole block
   always_comb begin
      nxt_s = s_ff;
      nxt_s.c1 = cmp_in;
      nxt_s.c2 = s_ff.c1;
      nxt_s.e1 = ext_trig_n;
      nxt_s.e2 = s_ff.e1;
      nxt_s.e3 = s_ff.e2;
      // Configuration is frozen while a conversion runs
      if (wr && hit_ctrl && s_ff.st == adcs_pkg::ADCS_IDLE) begin
         nxt_s.ctrl = pwdata[16:0];
         nxt_s.nch  = pwdata[`ADCS_F_STCH];
      end
      unique case (s_ff.st)
         adcs_pkg::ADCS_IDLE: begin
            if (trig) begin
               nxt_s.st  = adcs_pkg::ADCS_SAMP;
               nxt_s.cnt = 13'h0000;
               nxt_s.smp = 1'b1;
               nxt_s.ch  = start_ch;
            end
         end
         adcs_pkg::ADCS_SAMP: begin
            if (s_ff.cnt == samp_len - 13'h0001) begin
               nxt_s.st    = adcs_pkg::ADCS_CMP;
               nxt_s.cnt   = 13'h0000;
               nxt_s.smp   = 1'b0;
               nxt_s.trial = 10'h200;
               nxt_s.bitn  = 4'h9;
               nxt_s.stepc = 2'h0;
            end else begin
               nxt_s.cnt = s_ff.cnt + 13'h0001;
            end
         end
         adcs_pkg::ADCS_CMP: begin
            nxt_s.cnt   = s_ff.cnt + 13'h0001;
            nxt_s.stepc = s_ff.stepc + 2'h1;
            // Four cycles per bit cover the two synchroniser stages
            if (s_ff.stepc == `ADCS_STEP_LAST && sar_on) begin
               if (!s_ff.c2) begin
                  nxt_s.trial[s_ff.bitn] = 1'b0;
               end
               if (s_ff.bitn != lsb) begin
                  nxt_s.trial[s_ff.bitn - 4'h1] = 1'b1;
               end
               nxt_s.bitn = s_ff.bitn - 4'h1;
            end
            if (fin) begin
               nxt_s.res    = res_val;
               nxt_s.res_ch = s_ff.ch;
               nxt_s.cnt    = 13'h0000;
               unique case (mode)
                  adcs_pkg::ADCS_CONT: begin
                     nxt_s.st  = adcs_pkg::ADCS_SAMP;
                     nxt_s.smp = 1'b1;
                     nxt_s.ch  = adv;
                  end
                  adcs_pkg::ADCS_INCR: begin
                     nxt_s.st  = adcs_pkg::ADCS_IDLE;
                     nxt_s.nch = adv;
                  end
                  default: begin
                     if (last) begin
                        nxt_s.st = adcs_pkg::ADCS_IDLE;
                     end else begin
                        nxt_s.st  = adcs_pkg::ADCS_SAMP;
                        nxt_s.smp = 1'b1;
                        nxt_s.ch  = adv;
                     end
                  end
               endcase
            end
         end
         default: begin
            nxt_s.st  = adcs_pkg::ADCS_IDLE;
            nxt_s.smp = 1'b0;
         end
      endcase
      // Software abort wins over any sequencing step
      if (stop) begin
         nxt_s.st  = adcs_pkg::ADCS_IDLE;
         nxt_s.smp = 1'b0;
      end
      // Sticky flags: a new completion beats a clear in the same cycle
      nxt_s.done  = (s_ff.done & ~clr_done) | fin;
      nxt_s.xreq  = (s_ff.xreq & ~xfer_done) | fin_x;
      nxt_s.xdone = ~fin_x & ((s_ff.xreq & xfer_done) | s_ff.xdone);
      nxt_s.irq   = nxt_s.done & ien & (~transfer_service_enable | nxt_s.xdone);
      // APB answer: data captured in the first access cycle
      if (acc && !s_ff.rdy) begin
         nxt_s.rdy = 1'b1;
         nxt_s.err = bad;
         if (hit_ctrl) begin
            nxt_s.rdata = {15'h0000, s_ff.ctrl};
         end else if (hit_cmd) begin
            nxt_s.rdata = {20'h00000, s_ff.ch, s_ff.done, 7'h00,
                           s_ff.st != adcs_pkg::ADCS_IDLE};
         end else if (hit_res) begin
            nxt_s.rdata = {17'h00000, s_ff.res_ch, 2'h0, s_ff.res};
         end else begin
            nxt_s.rdata = 32'h00000000;
         end
      end else begin
         nxt_s.rdy = 1'b0;
         nxt_s.err = 1'b0;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '{st: adcs_pkg::ADCS_IDLE, ctrl: `ADCS_CTRL_RST,
                   e1: 1'b1, e2: 1'b1, e3: 1'b1, default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Outputs straight from the state register
   assign prdata    = s_ff.rdata;
   assign pready    = s_ff.rdy;
   assign pslverr   = s_ff.err;
   assign ch_sel    = s_ff.ch;
   assign sample_on = s_ff.smp;
   assign dac_code  = s_ff.trial;
   assign irq_req   = s_ff.irq;
   assign xfer_req  = s_ff.xreq;

   // Phase occupancy counters seen only by the checks below
   logic [12:0] h_smp;
   logic [12:0] h_cmp;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         h_smp <= 13'h0000;
         h_cmp <= 13'h0000;
      end else begin
         h_smp <= (s_ff.st == adcs_pkg::ADCS_SAMP && !fin) ?
                  h_smp + 13'h0001 : 13'h0000;
         h_cmp <= (s_ff.st == adcs_pkg::ADCS_CMP && !fin) ?
                  h_cmp + 13'h0001 : 13'h0000;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   samp_len_a: assert property (
      (s_ff.st == adcs_pkg::ADCS_SAMP && nxt_s.st == adcs_pkg::ADCS_CMP)
      |-> h_smp == samp_len - 13'h0001)
      else $error("sampling phase length wrong");
   cmp_len_a: assert property (
      fin |-> h_cmp == cmp_len - 13'h0001)
      else $error("compare phase length wrong");
   phase_order_a: assert property (
      (s_ff.st == adcs_pkg::ADCS_CMP && $past(s_ff.st) != s_ff.st)
      |-> $past(s_ff.st) == adcs_pkg::ADCS_SAMP)
      else $error("compare not preceded by sampling");
   res_narrow_a: assert property (
      (fin && !res10) |=> s_ff.res[9:8] == 2'h0)
      else $error("8-bit result has high bits set");
   ch_hold_a: assert property (
      s_ff.st == adcs_pkg::ADCS_CMP |-> $stable(ch_sel))
      else $error("channel changed during compare");
   ext_start_a: assert property (
      (s_ff.st == adcs_pkg::ADCS_IDLE && src == adcs_pkg::ADCS_TRG_EXT
       && ext_fall && !stop) |=> sample_on && ch_sel == $past(start_ch))
      else $error("pin fall did not start sampling");
   irq_plain_a: assert property (
      (fin && ien && !transfer_service_enable) |=> irq_req && !xfer_req)
      else $error("completion request missing");
   xfer_ack_a: assert property (
      (xfer_req && xfer_done && !fin && !clr_done && ien)
      |=> !xfer_req && irq_req)
      else $error("transfer end did not hand over");
   single_stop_a: assert property (
      (fin && mode == adcs_pkg::ADCS_SINGLE && last && !stop)
      |=> s_ff.st == adcs_pkg::ADCS_IDLE [*2])
      else $error("single scan did not stop");
   cont_wrap_a: assert property (
      (fin && mode == adcs_pkg::ADCS_CONT && last && !stop)
      |=> sample_on && ch_sel == $past(st_ch))
      else $error("continuous scan did not wrap");
   incr_one_a: assert property (
      (fin && mode == adcs_pkg::ADCS_INCR && !stop)
      |=> s_ff.st == adcs_pkg::ADCS_IDLE && s_ff.nch == $past(adv))
      else $error("incremental step wrong");
   latch_first_a: assert property (
      fin |=> s_ff.done && s_ff.res_ch == $past(s_ff.ch)
              && s_ff.res == $past(res_val))
      else $error("result not latched at completion");
   xfer_first_a: assert property (
      (fin && ien && transfer_service_enable) |=> xfer_req && !irq_req)
      else $error("interrupt came before transfer");
endmodule

// ==== rtl/adcs_map.svh ====
// adcs_map.svh: register offsets, field positions, reset values, timing.
// Assumes a 50 MHz pclk and 32-bit APB words at aligned byte addresses.
// Summary of operation
// - Sampling lasts 64, 128 or 4096 cycles
// - Compare lasts 44, 99 or 176 cycles
// - Conversion is sampling then compare
// - Result width is 8 or 10 bits
// - One of eight channels at a time
// - Start by software, timer or pin fall
// - Completion raises request when enabled
// - Completion may request autonomous transfer service
// - Single-shot: start to end, then stop
// - Continuous: start to end, repeat forever
// - Incremental: one channel per trigger, wrapping
// - Transfer first, then interrupt, when enabled
`ifndef ADCS_MAP_SVH
`define ADCS_MAP_SVH

// Register byte offsets
`define ADCS_CTRL_OFS  12'h000
`define ADCS_CMD_OFS   12'h004
`define ADCS_RES_OFS   12'h008

// Control register fields
`define ADCS_F_SAMP    1:0
`define ADCS_F_CMP     3:2
`define ADCS_F_RES10   4
`define ADCS_F_MODE    6:5
`define ADCS_F_TRIG    8:7
`define ADCS_F_IEN     9
`define ADCS_F_XSE     10
`define ADCS_F_STCH    13:11
`define ADCS_F_ENCH    16:14
`define ADCS_CTRL_RST  17'h00000

// Command / status fields
`define ADCS_F_GO      0
`define ADCS_F_STOP    1
`define ADCS_F_DONE    8

// Phase lengths in pclk cycles
`define ADCS_SAMP0     13'h0040
`define ADCS_SAMP1     13'h0080
`define ADCS_SAMP2     13'h1000
`define ADCS_CMP0      13'h002C
`define ADCS_CMP1      13'h0063
`define ADCS_CMP2      13'h00B0
`define ADCS_STEP_LAST 2'h3

// Least phase times that software must respect
`define ADCS_PCLK_NS     20
`define ADCS_SAMP_MIN_NS 4000
`define ADCS_CMP_MIN_NS  4400
`define ADCS_SAMP_MIN_CYC \
   ((`ADCS_SAMP_MIN_NS + `ADCS_PCLK_NS - 1) / `ADCS_PCLK_NS)
`define ADCS_CMP_MIN_CYC \
   ((`ADCS_CMP_MIN_NS + `ADCS_PCLK_NS - 1) / `ADCS_PCLK_NS)

`endif

// ==== rtl/adcs_pkg.sv ====
// adcs_pkg: state, mode and trigger types plus the state record.
// Assumes adcs_map.svh is on the include path.
`include "adcs_map.svh"
package adcs_pkg;
   typedef enum logic [1:0] {
      ADCS_IDLE = 2'b00,
      ADCS_SAMP = 2'b01,
      ADCS_CMP  = 2'b10
   } adcs_st_e;

   typedef enum logic [1:0] {
      ADCS_SINGLE = 2'b00,
      ADCS_CONT   = 2'b01,
      ADCS_INCR   = 2'b10
   } adcs_mode_e;

   typedef enum logic [1:0] {
      ADCS_TRG_SW  = 2'b00,
      ADCS_TRG_TMR = 2'b01,
      ADCS_TRG_EXT = 2'b10
   } adcs_trg_e;

   typedef struct packed {
      adcs_st_e    st;
      logic [12:0] cnt;
      logic [3:0]  bitn;
      logic [1:0]  stepc;
      logic [2:0]  ch;
      logic [2:0]  nch;
      logic [9:0]  trial;
      logic [9:0]  res;
      logic [2:0]  res_ch;
      logic        done;
      logic        xdone;
      logic [16:0] ctrl;
      logic [31:0] rdata;
      logic        rdy;
      logic        err;
      logic        irq;
      logic        xreq;
      logic        smp;
      logic        c1;
      logic        c2;
      logic        e1;
      logic        e2;
      logic        e3;
   } adcs_state_s;
endpackage

// ==== verification/adcs_front_model.sv ====
// adcs_front_model: analog inputs and transfer service beside adcs_top.
// Assumes ch_sel and dac_code are registered on pclk; comparator ideal.
`timescale 1ns/100ps
module adcs_front_model (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Converter side
   input  wire logic [2:0] ch_sel,
   input  wire logic [9:0] dac_code,
   output logic            cmp_in,
   // Transfer service
   input  wire logic       xfer_req,
   input  wire logic [3:0] xfer_lat,
   output logic            xfer_done
);
   logic [3:0] wait_cnt;

   // Each input sits at {channel, 7'h2B}, so a result names its source
   // Settles at once, so phase settings below the least times still convert right
   assign cmp_in = {ch_sel, 7'h2B} >= dac_code;

   // Service answers after xfer_lat cycles with a one-cycle pulse
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt  <= 4'h0;
         xfer_done <= 1'b0;
      end else begin
         xfer_done <= xfer_req && !xfer_done && wait_cnt == xfer_lat;
         wait_cnt  <= (xfer_req && !xfer_done) ? wait_cnt + 4'h1 : 4'h0;
      end
   end
endmodule

// ==== verification/adcs_conversion_sequencer_tb_top.sv ====
// Bench for adcs_top: APB tasks, timing, scan modes and transfer service.
// Assumes adcs_map.svh on the include path and the front model beside.
`timescale 1ns/100ps
`include "adcs_map.svh"
module adc_conversion_sequencer_tb_top;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        tmr_trig = 1'b0;
   logic        ext_trig_n = 1'b1;
   logic [3:0]  xfer_lat = 4'h5;
   logic [31:0] prdata, q;
   logic [2:0]  ch_sel;
   logic [9:0]  dac_code;
   logic        pready, pslverr, cmp_in, sample_on, xfer_done;
   logic        irq_req, xfer_req, err_seen;
   int          n_fail = 0;
   int          total_checks = 0;
   int          n;
   int          sl[3] = '{64, 128, 4096};
   int          cl[3] = '{44, 99, 176};
   int          cs[5] = '{6, 7, 0, 1, 6};

   // 50 MHz clock
   always #10 pclk = ~pclk;

   adcs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tmr_trig(tmr_trig), .ext_trig_n(ext_trig_n), .cmp_in(cmp_in),
      .ch_sel(ch_sel), .sample_on(sample_on), .dac_code(dac_code),
      .xfer_done(xfer_done), .irq_req(irq_req), .xfer_req(xfer_req));

   adcs_front_model u_front (.pclk(pclk), .presetn(presetn),
      .ch_sel(ch_sel), .dac_code(dac_code), .cmp_in(cmp_in),
      .xfer_req(xfer_req), .xfer_lat(xfer_lat), .xfer_done(xfer_done));

   // Verdict in one place only
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         $display("wrong value %s exp %h got %h", nm, e, g);
         n_fail++;
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int k;
      k = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      r = prdata;
      err_seen = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         n_fail++;
         complete_run();
      end
   endtask

   function automatic logic sg(input int s);
      case (s)
         0: sg = sample_on;
         1: sg = irq_req;
         default: sg = xfer_req;
      endcase
   endfunction

   // Counts edges until the chosen output reaches v; bounded
   task automatic wt(input int s, input logic v, output int c);
      c = 0;
      #1; // Never read an output in the time step of its launching edge
      while (sg(s) !== v) begin
         @(posedge pclk);
         #1;
         c++;
         if (c > 6000) begin
            n_fail++;
            complete_run();
         end
      end
   endtask

   function automatic logic [31:0] cf(input int s, c, r, m, t, ie, xe,
                                      st, en);
      cf = s | c << 2 | r << 4 | m << 5 | t << 7 | ie << 9 | xe << 10
         | st << 11 | en << 14;
   endfunction

   // Result the ideal input of channel c gives at the chosen width
   function automatic logic [31:0] resv(input logic [2:0] c,
                                        input logic r10);
      logic [9:0] v;
      v = {c, 7'h2B};
      resv = {17'h0, c, 2'h0, r10 ? v : {2'h0, v[9:2]}};
   endfunction

   task automatic clr;
      apb(1'b1, `ADCS_CMD_OFS, 32'h100, q);
   endtask

   // Main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `ADCS_CTRL_OFS, 32'h0, q);
      chk("ctrl_reset", 32'h0, q);
      chk("mapped_ok", 32'h0, err_seen);
      apb(1'b0, 12'h00C, 32'h0, q);
      chk("unmapped_err", 32'h1, err_seen);
      $display("test regs done");
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, `ADCS_CTRL_OFS, cf(i, i, 1, 0, 0, 1, 0, i+2, i+2), q);
         apb(1'b1, `ADCS_CMD_OFS, 32'h1, q);
         wt(0, 1'b1, n);
         chk("start_lat", 32'h0, n);
         wt(0, 1'b0, n);
         chk("samp_len", sl[i], n);
         chk("msb_first", 32'h200, dac_code);
         wt(1, 1'b1, n);
         chk("cmp_len", cl[i], n);
         apb(1'b0, `ADCS_RES_OFS, 32'h0, q);
         chk("result10", resv(i+2, 1'b1), q);
         clr();
         @(posedge pclk);
         #1;
         chk("irq_clear", 32'h0, irq_req);
      end
      $display("test timing done");
      apb(1'b1, `ADCS_CTRL_OFS, cf(0, 0, 0, 2, 1, 0, 0, 1, 2), q);
      for (int j = 0; j < 3; j++) begin
         @(posedge pclk);
         tmr_trig <= 1'b1;
         @(posedge pclk);
         tmr_trig <= 1'b0;
         wt(0, 1'b1, n);
         wt(0, 1'b0, n);
         repeat (46) @(posedge pclk);
         #1;
         chk("incr_wait", 32'h0, sample_on);
         chk("irq_off", 32'h0, irq_req);
         apb(1'b0, `ADCS_RES_OFS, 32'h0, q);
         chk("incr_res", resv(j % 2 + 1, 1'b0), q);
      end
      $display("test incremental done");
      apb(1'b1, `ADCS_CTRL_OFS, cf(0, 0, 1, 0, 2, 1, 0, 4, 5), q);
      @(posedge pclk);
      ext_trig_n <= 1'b0;
      for (int j = 4; j < 6; j++) begin
         wt(0, 1'b1, n);
         chk("single_ch", j, ch_sel);
         wt(0, 1'b0, n);
      end
      @(posedge pclk);
      ext_trig_n <= 1'b1;
      repeat (45) @(posedge pclk);
      apb(1'b0, `ADCS_CMD_OFS, 32'h0, q);
      chk("single_stop", 32'h100, {q[8], 7'h0, q[0]});
      apb(1'b0, `ADCS_RES_OFS, 32'h0, q);
      chk("single_res", resv(5, 1'b1), q);
      clr();
      $display("test single done");
      apb(1'b1, `ADCS_CTRL_OFS, cf(0, 0, 1, 1, 0, 0, 0, 6, 1), q);
      apb(1'b1, `ADCS_CMD_OFS, 32'h1, q);
      for (int j = 0; j < 5; j++) begin
         wt(0, 1'b1, n);
         chk("cont_ch", cs[j], ch_sel);
         wt(0, 1'b0, n);
      end
      apb(1'b1, `ADCS_CMD_OFS, 32'h102, q);
      apb(1'b0, `ADCS_CMD_OFS, 32'h0, q);
      chk("cont_busy", 32'h0, q[0]);
      $display("test continuous done");
      apb(1'b1, `ADCS_CTRL_OFS, cf(0, 0, 1, 0, 0, 1, 1, 3, 3), q);
      apb(1'b1, `ADCS_CMD_OFS, 32'h1, q);
      wt(2, 1'b1, n);
      chk("xfer_first", 32'h0, irq_req);
      wt(1, 1'b1, n);
      chk("xfer_drop", 32'h0, xfer_req);
      $display("test transfer done");
      complete_run();
   end
endmodule
